// *** inc/rlis_pkg.sv ***
package rlis_pkg;
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned DATA_CLK_MHZ      = 1250;
  localparam int unsigned SYNC_WAIT_PERIODS = 160000;
  localparam int unsigned RX_WAIT_PERIODS   = 135000;
  localparam int unsigned SYNC_WAIT_CYCLES  =
    (SYNC_WAIT_PERIODS * CLK_MHZ + DATA_CLK_MHZ - 1) / DATA_CLK_MHZ;
  localparam int unsigned RX_WAIT_CYCLES    =
    (RX_WAIT_PERIODS * CLK_MHZ + DATA_CLK_MHZ - 1) / DATA_CLK_MHZ;
  localparam logic [3:0]  SPI_HALF_CYCLES   = 4'h4;
  localparam logic [3:0]  SPI_LAST_BIT      = 4'hF;
  localparam logic [1:0]  MAX_ATTEMPTS      = 2'h3;
  // ==========================================================================
  // Device register addresses and values
  localparam logic [6:0] DEV_PORT_CFG    = 7'h00;
  localparam logic [6:0] DEV_CUR_LO      = 7'h06;
  localparam logic [6:0] DEV_CUR_HI      = 7'h07;
  localparam logic [6:0] DEV_MODE        = 7'h08;
  localparam logic [6:0] DEV_CLK_STATUS  = 7'h0D;
  localparam logic [6:0] DEV_CTRL        = 7'h10;
  localparam logic [6:0] DEV_SKEW        = 7'h13;
  localparam logic [6:0] DEV_CODE_HI     = 7'h14;
  localparam logic [6:0] DEV_LOCK_STATUS = 7'h21;
  localparam logic [7:0] VAL_SOFT_RESET  = 8'h20;
  localparam logic [7:0] VAL_RESET_CLEAR = 8'h00;
  localparam logic [7:0] VAL_SYNC_OFF    = 8'h00;
  localparam logic [7:0] VAL_LOOP_MASTER = 8'h60;
  localparam logic [7:0] VAL_LOOP_SLAVE  = 8'h40;
  localparam logic [3:0] NIB_ON_MASTER   = 4'h7;
  localparam logic [3:0] NIB_ON_SLAVE    = 4'h5;
  localparam logic [3:0] NIB_RX_OFF      = 4'h0;
  localparam logic [3:0] NIB_RX_LOOP     = 4'h2;
  localparam logic [3:0] NIB_RX_TRACK    = 4'h3;
  localparam logic [7:0] VAL_SKEW        = 8'h72;
  localparam logic [7:0] VAL_LOCK_MASTER = 8'h90;
  localparam logic [7:0] VAL_LOCK_SLAVE  = 8'h00;
  localparam logic [1:0] VAL_CLK_FIELD   = 2'h2;
  localparam int unsigned CLK_FIELD_LSB  = 4;
  localparam logic [7:0] VAL_RX_LOCKED   = 8'h09;
  localparam logic [9:0] CODE_TOLERANCE  = 10'h028;
  // ==========================================================================
  // Wishbone register offsets, fields and reset values
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFF_CURRENT  = 8'h14;
  localparam logic [7:0] OFF_MODE     = 8'h18;
  localparam logic [7:0] OFF_MCODE    = 8'h1C;
  localparam logic [7:0] OFF_RCODE    = 8'h20;
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_MASTER = 1;
  localparam int unsigned CTRL_MULTI  = 2;
  localparam int unsigned CTRL_CUR    = 3;
  localparam int unsigned CTRL_MODE   = 4;
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_SYNC    = 1;
  localparam int unsigned IRQ_RX      = 2;
  localparam int unsigned IRQ_CODE    = 3;
  localparam int unsigned IRQ_W       = 4;
  localparam logic [7:0] RST_CUR_LO   = 8'h00;
  localparam logic [7:0] RST_CUR_HI   = 8'h02;
  localparam logic [7:0] RST_MODE     = 8'h00;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic       read;
    logic [6:0] addr;
    logic [7:0] data;
  } rlis_spi_req_type;

  typedef enum logic [4:0] {
    ST_IDLE       = 5'h00,
    ST_SYNC_OFF   = 5'h01,
    ST_SYNC_LOOP  = 5'h03,
    ST_SYNC_ON    = 5'h02,
    ST_SYNC_WAIT  = 5'h06,
    ST_SYNC_CHECK = 5'h07,
    ST_CLK_CHECK  = 5'h05,
    ST_SKEW       = 5'h04,
    ST_RX_OFF     = 5'h0C,
    ST_RX_LOOP    = 5'h0D,
    ST_RX_TRACK   = 5'h0F,
    ST_RX_WAIT    = 5'h0E,
    ST_RX_CHECK   = 5'h0A,
    ST_CODE_LO    = 5'h0B,
    ST_CODE_HI    = 5'h09,
    ST_CUR_LO     = 5'h08,
    ST_CUR_HI     = 5'h18,
    ST_MODE_SET   = 5'h19,
    ST_SRST       = 5'h1B,
    ST_SRST_CLR   = 5'h1A
  } rlis_state_type;
endpackage : rlis_pkg

// *** src/rlis_top.sv ***
// Notes on behaviour
// R1 - After sync lock, read 0x21: 0x90 master, 0x00 slave; else redo sync setup.
// R2 - Read 0x0D, bits 5:4 must be 10; else soft reset again, three tries.
// R3 - The data source must already supply the data clock before receive bring-up.
// R4 - Write 0x72 to 0x13, fine data clock skew of 2.
// R5 - Disable receive controller: 0x10 low nibble 0, upper nibble 7 or 5.
// R6 - Then 0x10 low nibble 2: receive loop and interrupt enabled.
// R7 - Then 0x10 low nibble 3: receive search and track.
// R8 - Wait 135K data clocks, expect 0x09 in 0x21; else retry, three tries.
// R9 - Multi-device: read delay code, beyond 40 apart set target to average.
// R10 - Optionally write full scale current registers 0x06 and 0x07.
// R11 - Optionally write operation mode register 0x08.
// R12 - Disable sync controller with 0x00 in 0x10; receive retries return here.
// R13 - Sync loop enable 0x60 or 0x40, then full enable 0x70 or 0x50.
// R14 - One attempt counter per retry loop; three failures stop and flag.
`timescale 1ns/10ps
module rlis_top #(
  parameter int unsigned SYNC_WAIT = rlis_pkg::SYNC_WAIT_CYCLES,
  parameter int unsigned RX_WAIT   = rlis_pkg::RX_WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdata,
  output logic      [31:0] wb_rdata,
  output logic             wb_ack,
  output logic             irq,
  // Device serial port and data clock presence
  output logic             spi_sclk,
  output logic             spi_csn,
  output logic             spi_sdio,
  input  wire logic        spi_sdo,
  input  wire logic        data_clock_ready
);
  // ==========================================================================
  // Declarations
  rlis_pkg::rlis_state_type   state;
  rlis_pkg::rlis_state_type   next_state;
  rlis_pkg::rlis_spi_req_type op_req;
  logic [4:0]             ctrl;
  logic [rlis_pkg::IRQ_W-1:0] irq_stat;
  logic [rlis_pkg::IRQ_W-1:0] irq_en;
  logic [15:0]            cur_val;
  logic [7:0]             mode_val;
  logic [9:0]             master_code;
  logic [9:0]             readback_code;
  logic [9:0]             target_code;
  logic [7:0]             code_lo;
  logic [1:0]             sync_tries;
  logic [1:0]             reset_tries;
  logic [1:0]             rx_tries;
  logic [1:0]             next_sync_tries;
  logic [1:0]             next_reset_tries;
  logic [1:0]             next_rx_tries;
  logic [23:0]            wait_cnt;
  logic                   issued;
  logic                   sync_fail_evt;
  logic                   rx_fail_evt;
  logic [2:0]             flags;
  logic [1:0]             sdo_sync;
  logic [1:0]             dck_sync;
  logic                   spi_busy;
  logic                   spi_done;
  logic [3:0]             half_cnt;
  logic [3:0]             bit_cnt;
  logic [15:0]            shift_out;
  logic [7:0]             spi_rdata;
  logic [31:0]            next_rdata;

  // ==========================================================================
  // Wishbone decode
  wire        access    = wb_cyc & wb_stb;
  wire        wr_take   = access & wb_we & wb_ack;
  wire [31:0] lane_mask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  wire        wr_ctrl   = wr_take & (wb_adr == rlis_pkg::OFF_CTRL) & wb_sel[0];
  wire        wr_clr    = wr_take & (wb_adr == rlis_pkg::OFF_IRQ_CLR);
  wire        wr_en     = wr_take & (wb_adr == rlis_pkg::OFF_IRQ_EN);
  wire        wr_cur    = wr_take & (wb_adr == rlis_pkg::OFF_CURRENT);
  wire        wr_mode   = wr_take & (wb_adr == rlis_pkg::OFF_MODE) & wb_sel[0];
  wire        wr_mcode  = wr_take & (wb_adr == rlis_pkg::OFF_MCODE);
  wire        idle      = (state == rlis_pkg::ST_IDLE);
  wire        start     = wr_ctrl & wb_wdata[rlis_pkg::CTRL_START] & idle;
  wire        is_master = ctrl[rlis_pkg::CTRL_MASTER];
  wire [31:0] new_mcode = ({22'h000000, master_code} & ~lane_mask) | (wb_wdata & lane_mask);
  wire [31:0] new_cur   = ({16'h0000, cur_val} & ~lane_mask) | (wb_wdata & lane_mask);
  wire [31:0] status    = {14'h0000, rx_tries, reset_tries, sync_tries, 3'h0, state,
                           flags, ~idle};
  wire [rlis_pkg::IRQ_W-1:0] clr_mask = wb_wdata[rlis_pkg::IRQ_W-1:0];

  always_comb
  begin
    unique case (wb_adr)
      rlis_pkg::OFF_CTRL:     next_rdata = {27'h0000000, ctrl};
      rlis_pkg::OFF_STATUS:   next_rdata = status;
      rlis_pkg::OFF_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
      rlis_pkg::OFF_IRQ_EN:   next_rdata = {28'h0000000, irq_en};
      rlis_pkg::OFF_CURRENT:  next_rdata = {16'h0000, cur_val};
      rlis_pkg::OFF_MODE:     next_rdata = {24'h000000, mode_val};
      rlis_pkg::OFF_MCODE:    next_rdata = {22'h000000, master_code};
      rlis_pkg::OFF_RCODE:    next_rdata = {6'h00, target_code, 6'h00, readback_code};
      default:                next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack   <= 1'b0;
      wb_rdata <= 32'h00000000;
    end
    else
    begin
      wb_ack   <= access & ~wb_ack;
      wb_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl        <= 5'h00;
      irq_en      <= 4'h0;
      cur_val     <= {rlis_pkg::RST_CUR_HI, rlis_pkg::RST_CUR_LO};
      mode_val    <= rlis_pkg::RST_MODE;
      master_code <= 10'h000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {wb_wdata[4:1], 1'b0};
      if (wr_en & wb_sel[0])
        irq_en <= wb_wdata[rlis_pkg::IRQ_W-1:0];
      if (wr_cur)
        cur_val <= new_cur[15:0];
      if (wr_mode)
        mode_val <= wb_wdata[7:0];
      if (wr_mcode)
        master_code <= new_mcode[9:0];
    end
  end

  // ==========================================================================
  // Interrupts: a new event wins over a clear in the same cycle.
  wire [9:0]  rb_code   = {spi_rdata[1:0], code_lo};
  wire [9:0]  code_diff = (rb_code >= master_code) ? 10'(rb_code - master_code)
                                                   : 10'(master_code - rb_code);
  wire [10:0] code_sum  = {1'b0, rb_code} + {1'b0, master_code};
  wire code_fix  = (state == rlis_pkg::ST_CODE_HI) & spi_done
                   & (code_diff > rlis_pkg::CODE_TOLERANCE);
  wire done_evt  = spi_done & ~idle & (next_state == rlis_pkg::ST_IDLE) & ~sync_fail_evt
                   & ~rx_fail_evt;
  wire [rlis_pkg::IRQ_W-1:0] events = {code_fix, rx_fail_evt, sync_fail_evt, done_evt};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_stat <= 4'h0;
    else
      irq_stat <= (irq_stat & ~(wr_clr & wb_sel[0] ? clr_mask : 4'h0)) | events;
  end

  assign irq = |(irq_stat & irq_en);

  // ==========================================================================
  // Input synchronisers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sdo_sync <= 2'h0;
      dck_sync <= 2'h0;
    end
    else
    begin
      sdo_sync <= {sdo_sync[0], spi_sdo};
      dck_sync <= {dck_sync[0], data_clock_ready};
    end
  end

  // ==========================================================================
  // Delay code reconciliation

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code_lo       <= 8'h00;
      readback_code <= 10'h000;
      target_code   <= 10'h000;
    end
    else
    begin
      if ((state == rlis_pkg::ST_CODE_LO) && spi_done)
        code_lo <= spi_rdata;
      if ((state == rlis_pkg::ST_CODE_HI) && spi_done)
      begin
        readback_code <= rb_code;
        target_code   <= code_fix ? code_sum[10:1] : master_code; // R9
      end
    end
  end

  // ==========================================================================
  // Device command per state
  function automatic rlis_pkg::rlis_spi_req_type state_req(
    input rlis_pkg::rlis_state_type st,
    input logic                     master,
    input logic [15:0]              cur,
    input logic [7:0]               mode
  );
    logic [3:0] nib;
    nib = master ? rlis_pkg::NIB_ON_MASTER : rlis_pkg::NIB_ON_SLAVE;
    unique case (st)
      rlis_pkg::ST_SYNC_OFF:   state_req = '{1'b0, rlis_pkg::DEV_CTRL, rlis_pkg::VAL_SYNC_OFF};
      rlis_pkg::ST_SYNC_LOOP:  state_req = '{1'b0, rlis_pkg::DEV_CTRL,
        master ? rlis_pkg::VAL_LOOP_MASTER : rlis_pkg::VAL_LOOP_SLAVE};
      rlis_pkg::ST_SYNC_ON:    state_req = '{1'b0, rlis_pkg::DEV_CTRL, {nib, 4'h0}};
      rlis_pkg::ST_SKEW:       state_req = '{1'b0, rlis_pkg::DEV_SKEW, rlis_pkg::VAL_SKEW};
      rlis_pkg::ST_RX_OFF:     state_req = '{1'b0, rlis_pkg::DEV_CTRL, {nib, rlis_pkg::NIB_RX_OFF}};
      rlis_pkg::ST_RX_LOOP:    state_req = '{1'b0, rlis_pkg::DEV_CTRL, {nib, rlis_pkg::NIB_RX_LOOP}};
      rlis_pkg::ST_RX_TRACK:   state_req = '{1'b0, rlis_pkg::DEV_CTRL, {nib, rlis_pkg::NIB_RX_TRACK}};
      rlis_pkg::ST_SYNC_CHECK: state_req = '{1'b1, rlis_pkg::DEV_LOCK_STATUS, 8'h00};
      rlis_pkg::ST_RX_CHECK:   state_req = '{1'b1, rlis_pkg::DEV_LOCK_STATUS, 8'h00};
      rlis_pkg::ST_CLK_CHECK:  state_req = '{1'b1, rlis_pkg::DEV_CLK_STATUS, 8'h00};
      rlis_pkg::ST_CODE_LO:    state_req = '{1'b1, rlis_pkg::DEV_SKEW, 8'h00};
      rlis_pkg::ST_CODE_HI:    state_req = '{1'b1, rlis_pkg::DEV_CODE_HI, 8'h00};
      rlis_pkg::ST_CUR_LO:     state_req = '{1'b0, rlis_pkg::DEV_CUR_LO, cur[7:0]};
      rlis_pkg::ST_CUR_HI:     state_req = '{1'b0, rlis_pkg::DEV_CUR_HI, cur[15:8]};
      rlis_pkg::ST_MODE_SET:   state_req = '{1'b0, rlis_pkg::DEV_MODE, mode};
      rlis_pkg::ST_SRST:       state_req = '{1'b0, rlis_pkg::DEV_PORT_CFG, rlis_pkg::VAL_SOFT_RESET};
      rlis_pkg::ST_SRST_CLR:   state_req = '{1'b0, rlis_pkg::DEV_PORT_CFG,
        rlis_pkg::VAL_RESET_CLEAR};
      default:                 state_req = '{1'b1, 7'h00, 8'h00};
    endcase
  endfunction : state_req

  assign op_req = state_req(state, is_master, cur_val, mode_val);

  // The skew write opens the receive bring-up, so it waits for the data clock.
  wire is_op   = ~idle & (state != rlis_pkg::ST_SYNC_WAIT) & (state != rlis_pkg::ST_RX_WAIT);
  wire dck_ok  = (state != rlis_pkg::ST_SKEW) | dck_sync[1]; // R3
  wire spi_go  = is_op & ~issued & ~spi_busy & dck_ok;
  wire is_wait = (state == rlis_pkg::ST_SYNC_WAIT) | (state == rlis_pkg::ST_RX_WAIT);
  wire sync_wait_over = wait_cnt == 24'(SYNC_WAIT - 1);
  wire rx_wait_over   = wait_cnt == 24'(RX_WAIT - 1);
  wire sync_locked = spi_rdata == (is_master ? rlis_pkg::VAL_LOCK_MASTER
                                             : rlis_pkg::VAL_LOCK_SLAVE);
  wire clk_ok  = spi_rdata[rlis_pkg::CLK_FIELD_LSB +: 2] == rlis_pkg::VAL_CLK_FIELD;
  wire rx_locked = spi_rdata == rlis_pkg::VAL_RX_LOCKED;
  wire [4:0] after_cur  = ctrl[rlis_pkg::CTRL_MODE] ? rlis_pkg::ST_MODE_SET : rlis_pkg::ST_IDLE;
  wire [4:0] after_code = ctrl[rlis_pkg::CTRL_CUR] ? rlis_pkg::ST_CUR_LO : after_cur;
  wire [4:0] after_rx   = ctrl[rlis_pkg::CTRL_MULTI] ? rlis_pkg::ST_CODE_LO : after_code;

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    next_state       = state;
    next_sync_tries  = sync_tries;
    next_reset_tries = reset_tries;
    next_rx_tries    = rx_tries;
    sync_fail_evt    = 1'b0;
    rx_fail_evt      = 1'b0;
    unique case (state)
      rlis_pkg::ST_IDLE:
        if (start)
        begin
          next_state       = rlis_pkg::ST_SYNC_OFF;
          next_sync_tries  = 2'h0;
          next_reset_tries = 2'h0;
          next_rx_tries    = 2'h0;
        end
      rlis_pkg::ST_SYNC_OFF:  if (spi_done) next_state = rlis_pkg::ST_SYNC_LOOP; // R12
      rlis_pkg::ST_SYNC_LOOP: if (spi_done) next_state = rlis_pkg::ST_SYNC_ON; // R13
      rlis_pkg::ST_SYNC_ON:   if (spi_done) next_state = rlis_pkg::ST_SYNC_WAIT; // R13
      rlis_pkg::ST_SYNC_WAIT: if (sync_wait_over) next_state = rlis_pkg::ST_SYNC_CHECK;
      rlis_pkg::ST_SYNC_CHECK:
        if (spi_done && sync_locked) // R1
          next_state = rlis_pkg::ST_CLK_CHECK;
        else if (spi_done && (2'(sync_tries + 2'h1) == rlis_pkg::MAX_ATTEMPTS)) // R14
        begin
          next_state    = rlis_pkg::ST_IDLE;
          sync_fail_evt = 1'b1;
        end
        else if (spi_done)
        begin
          next_sync_tries = 2'(sync_tries + 2'h1);
          next_state      = rlis_pkg::ST_SYNC_OFF; // R1
        end
      rlis_pkg::ST_CLK_CHECK:
        if (spi_done && clk_ok) // R2
          next_state = rlis_pkg::ST_SKEW;
        else if (spi_done && (2'(reset_tries + 2'h1) == rlis_pkg::MAX_ATTEMPTS)) // R14
        begin
          next_state    = rlis_pkg::ST_IDLE;
          sync_fail_evt = 1'b1;
        end
        else if (spi_done)
        begin
          next_reset_tries = 2'(reset_tries + 2'h1);
          next_state       = rlis_pkg::ST_SRST; // R2
        end
      rlis_pkg::ST_SRST:     if (spi_done) next_state = rlis_pkg::ST_SRST_CLR;
      rlis_pkg::ST_SRST_CLR: if (spi_done) next_state = rlis_pkg::ST_SYNC_OFF;
      rlis_pkg::ST_SKEW:     if (spi_done) next_state = rlis_pkg::ST_RX_OFF; // R4
      rlis_pkg::ST_RX_OFF:   if (spi_done) next_state = rlis_pkg::ST_RX_LOOP; // R5
      rlis_pkg::ST_RX_LOOP:  if (spi_done) next_state = rlis_pkg::ST_RX_TRACK; // R6
      rlis_pkg::ST_RX_TRACK: if (spi_done) next_state = rlis_pkg::ST_RX_WAIT; // R7
      rlis_pkg::ST_RX_WAIT:  if (rx_wait_over) next_state = rlis_pkg::ST_RX_CHECK; // R8
      rlis_pkg::ST_RX_CHECK:
        if (spi_done && rx_locked) // R8
          next_state = rlis_pkg::rlis_state_type'(after_rx);
        else if (spi_done && (2'(rx_tries + 2'h1) == rlis_pkg::MAX_ATTEMPTS)) // R14
        begin
          next_state  = rlis_pkg::ST_IDLE;
          rx_fail_evt = 1'b1;
        end
        else if (spi_done)
        begin
          next_rx_tries = 2'(rx_tries + 2'h1);
          next_state    = rlis_pkg::ST_SYNC_OFF; // R12
        end
      rlis_pkg::ST_CODE_LO:  if (spi_done) next_state = rlis_pkg::ST_CODE_HI; // R9
      rlis_pkg::ST_CODE_HI:
        if (spi_done) next_state = rlis_pkg::rlis_state_type'(after_code);
      rlis_pkg::ST_CUR_LO:   if (spi_done) next_state = rlis_pkg::ST_CUR_HI; // R10
      rlis_pkg::ST_CUR_HI:
        if (spi_done) next_state = rlis_pkg::rlis_state_type'(after_cur); // R10
      rlis_pkg::ST_MODE_SET: if (spi_done) next_state = rlis_pkg::ST_IDLE; // R11
      default:               next_state = rlis_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= rlis_pkg::ST_IDLE;
      sync_tries  <= 2'h0;
      reset_tries <= 2'h0;
      rx_tries    <= 2'h0;
      issued      <= 1'b0;
      wait_cnt    <= 24'h000000;
      flags       <= 3'h0;
    end
    else
    begin
      state       <= next_state;
      sync_tries  <= next_sync_tries;
      reset_tries <= next_reset_tries;
      rx_tries    <= next_rx_tries;
      issued      <= spi_go | (issued & ~spi_done);
      wait_cnt    <= is_wait ? 24'(wait_cnt + 24'h000001) : 24'h000000;
      if (start)
        flags <= 3'h0;
      else
        flags <= flags | {rx_fail_evt, sync_fail_evt, done_evt};
    end
  end

  // ==========================================================================
  // Serial port: 16-bit frame, clock idles low, data out on the falling edge.
  // Sampling uses the synchronised input, so the half period must exceed two clocks.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      spi_busy  <= 1'b0;
      spi_done  <= 1'b0;
      spi_csn   <= 1'b1;
      spi_sclk  <= 1'b0;
      half_cnt  <= 4'h0;
      bit_cnt   <= 4'h0;
      shift_out <= 16'h0000;
      spi_rdata <= 8'h00;
    end
    else
    begin
      spi_done <= 1'b0;
      if (spi_go)
      begin
        spi_busy  <= 1'b1;
        spi_csn   <= 1'b0;
        half_cnt  <= 4'h0;
        bit_cnt   <= 4'h0;
        shift_out <= op_req;
      end
      else if (spi_busy && (half_cnt == 4'(rlis_pkg::SPI_HALF_CYCLES - 4'h1)))
      begin
        half_cnt <= 4'h0;
        spi_sclk <= ~spi_sclk;
        if (!spi_sclk)
          spi_rdata <= {spi_rdata[6:0], sdo_sync[1]};
        else
        begin
          shift_out <= {shift_out[14:0], 1'b0};
          bit_cnt   <= 4'(bit_cnt + 4'h1);
          if (bit_cnt == rlis_pkg::SPI_LAST_BIT)
          begin
            spi_busy <= 1'b0;
            spi_csn  <= 1'b1;
            spi_done <= 1'b1;
          end
        end
      end
      else if (spi_busy)
        half_cnt <= 4'(half_cnt + 4'h1);
    end
  end

  assign spi_sdio = shift_out[15];
endmodule : rlis_top

// *** testbench/rlis_properties.sv ***
`timescale 1ns/10ps
module rlis_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus and serial port
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdio
);
  // ==========================================================================
  // Handshake and frame shape
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ACK_NEXT: assert property ($rose(wb_cyc && wb_stb) |=> wb_ack) else $error("late ack");
  AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack) else $error("long ack");
  AST_ACK_IDLE: assert property (!(wb_cyc && wb_stb) |=> !wb_ack) else $error("stray ack");
  AST_SCLK_IDLE: assert property (spi_csn |-> !spi_sclk) else $error("sclk idle");
  AST_FRAME: assert property ($fell(spi_csn) |-> ##127 !spi_csn ##1 spi_csn) else $error("frame");
  AST_HIGH: assert property ($rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk) else $error("high");
  AST_LOW: assert property ($fell(spi_sclk) && !spi_csn |-> !spi_sclk [*4]) else $error("low");
  AST_SDIO: assert property (spi_sclk |-> $stable(spi_sdio)) else $error("sdio moved");
  COV_FRAME: cover property ($fell(spi_csn));
  COV_ACK: cover property (wb_ack);
  COV_BACK: cover property (wb_ack ##2 wb_ack);
endmodule : rlis_properties
bind rlis_top rlis_properties u_prop (.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_ack(wb_ack), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdio(spi_sdio));

// *** testbench/rlis_dev_model.sv ***
`timescale 1ns/10ps
module rlis_dev_model (
  // Serial port
  input  wire logic spi_sclk,
  input  wire logic spi_csn,
  input  wire logic spi_sdio,
  output logic      spi_sdo,
  // Scenario controls
  input  wire logic sync_ok,
  input  wire logic rx_ok
);
  // ==========================================================================
  // Register file, with a log of control writes
  logic [7:0]  regs [0:127];
  logic [7:0]  q10 [$];
  logic [15:0] sh;
  logic [7:0]  rd;
  logic [7:0]  v21;
  int          cnt;
  assign v21 = (regs[16][3:0] == 4'h3) ? (rx_ok ? 8'h09 : 8'h01) :
    (sync_ok ? ((regs[16][7:4] == 4'h7) ? 8'h90 : 8'h00) : 8'h11);
  initial
  begin
    foreach (regs[i]) regs[i] = 8'h00;
    regs[7] = 8'h02;
    regs[13] = 8'h20;
    spi_sdo = 1'b0;
    cnt = 0;
  end
  always @(negedge spi_csn) cnt = 0;
  always @(posedge spi_sclk)
  begin
    sh = {sh[14:0], spi_sdio};
    cnt = cnt + 1;
    if (cnt == 8) rd = (sh[6:0] == 7'h21) ? v21 : regs[sh[6:0]];
    if (cnt == 16 && !sh[15]) regs[sh[14:8]] = sh[7:0];
    if (cnt == 16 && !sh[15] && sh[14:8] == 7'h10) q10.push_back(sh[7:0]);
  end
  // A released line shows the inverse so a stale bit can never pass as data.
  always @(negedge spi_sclk or posedge spi_csn)
  begin
    if (spi_csn) spi_sdo <= ~spi_sdo;
    else if (cnt >= 8 && cnt < 16) spi_sdo <= rd[7 - (cnt - 8)];
  end
endmodule : rlis_dev_model

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, irq, sclk, csn, sdio, sdo, dok, sok, rok;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdata, wb_rdata, d;
  int          failures, compares, seed, cur, mode, mc, rc, tgt;
  rlis_top #(.SYNC_WAIT(20), .RX_WAIT(20)) uut (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hF), .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata), .wb_ack(wb_ack), .irq(irq), .spi_sclk(sclk), .spi_csn(csn),
    .spi_sdio(sdio), .spi_sdo(sdo), .data_clock_ready(dok));
  rlis_dev_model dev (.spi_sclk(sclk), .spi_csn(csn), .spi_sdio(sdio), .spi_sdo(sdo),
    .sync_ok(sok), .rx_ok(rok));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) failures++;
    if (seen !== exp) $display("BAD %0t seen %h expected %h", $time, seen, exp);
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdata} <= {2'b11, we, a, w};
    do @(posedge clk); while (wb_ack !== 1'b1);
    d = wb_rdata;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb
  // Runs one sequence, then checks every control write in order for each attempt.
  task run(input logic [31:0] ctl, input int tries, input int per);
    logic [7:0] e [6];
    e = '{8'h00, ctl[1] ? 8'h60 : 8'h40, 8'h50, 8'h50, 8'h52, 8'h53};
    for (int i = 2; i < 6; i++) e[i][5] = ctl[1];
    dev.q10.delete();
    wb(1, rlis_pkg::OFF_CTRL, ctl);
    do wb(0, rlis_pkg::OFF_STATUS, 0); while (d[0] !== 1'b0);
    chk(dev.q10.size(), per * tries);
    foreach (dev.q10[i]) chk(dev.q10[i], e[i % per]);
  endtask : run
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    #500000 failures++;
    end_sim();
  end
  initial
  begin
    {rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdata, dok, sok, rok} = {4'h9, 40'h0, 3'h7};
    seed = 32'hb7f6e2fa;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(0, rlis_pkg::OFF_CURRENT, 0);
    chk(d, 32'h0200);
    wb(0, 8'h3C, 0);
    chk(d, 0);
    cur = $random(seed) & 16'hFFFF;
    mode = $random(seed) & 8'hFF;
    wb(1, rlis_pkg::OFF_IRQ_EN, 32'hF);
    wb(1, rlis_pkg::OFF_CURRENT, cur);
    wb(1, rlis_pkg::OFF_MODE, mode);
    run(32'h1B, 1, 6);
    chk({dev.regs[19], dev.regs[7], dev.regs[6], dev.regs[8]}, {8'h72, cur[15:0], mode[7:0]});
    chk(irq, 1);
    wb(1, rlis_pkg::OFF_IRQ_CLR, 32'hF);
    @(posedge clk);
    chk(irq, 0);
    $display("test 1 done");
    rok = 0;
    wb(1, rlis_pkg::OFF_IRQ_EN, 0);
    run(32'h05, 3, 6);
    chk({irq, d[3]}, 2'b01);
    wb(1, rlis_pkg::OFF_IRQ_EN, 32'h4);
    @(posedge clk);
    chk(irq, 1);
    wb(1, rlis_pkg::OFF_IRQ_CLR, 32'hF);
    $display("test 2 done");
    rok = 1;
    dev.regs[20] = $random(seed);
    mc = $random(seed) & 10'h3FF;
    rc = {dev.regs[20][1:0], 8'h72};
    tgt = (mc - rc > 40 || rc - mc > 40) ? (mc + rc) / 2 : mc;
    wb(1, rlis_pkg::OFF_MCODE, mc);
    run(32'h05, 1, 6);
    wb(0, rlis_pkg::OFF_RCODE, 0);
    chk(d, (tgt << 16) | rc);
    $display("test 3 done");
    sok = 0;
    run(32'h01, 3, 3);
    chk(d[2], 1);
    $display("test 4 done");
    sok = 1;
    dev.regs[13] = 8'h10;
    run(32'h03, 3, 3);
    chk(d[2], 1);
    $display("test 5 done");
    end_sim();
  end
endmodule : testbench
